//--- hw/vrsm_defines.svh
`ifndef VRSM_DEFINES_SVH
`define VRSM_DEFINES_SVH

// register offsets
`define VRSM_OFS_EMERG 8'h4f
`define VRSM_OFS_SMCTL 8'h50
`define VRSM_OFS_SMDLY 8'h51

// reset values
`define VRSM_RST_EMERG 8'h30
`define VRSM_RST_SMCTL 8'h07
`define VRSM_RST_SMDLY 8'h00

// field positions
`define VRSM_EM_RATE_HI 7
`define VRSM_EM_RATE_LO 6
`define VRSM_EM_STEP_HI 5
`define VRSM_EM_STEP_LO 4
`define VRSM_SM_JOINT 2
`define VRSM_SM_EN_R 1
`define VRSM_SM_EN_L 0
`define VRSM_DLY_L_HI 6
`define VRSM_DLY_L_LO 4
`define VRSM_DLY_R_HI 2
`define VRSM_DLY_R_LO 0

// rate and step codes, step amounts in 0.5 dB volume units
`define VRSM_RATE_FS1 2'h0
`define VRSM_RATE_FS2 2'h1
`define VRSM_RATE_FS4 2'h2
`define VRSM_RATE_INSTANT 2'h3
`define VRSM_STEP_4DB 8'h08
`define VRSM_STEP_2DB 8'h04
`define VRSM_STEP_1DB 8'h02
`define VRSM_STEP_HALF_DB 8'h01
`define VRSM_VOL_MUTE 8'hff

// silence delays in microseconds at the reference sample rate
`define VRSM_SM_RATE_HZ 96000
`define VRSM_SM_T0_US 11500
`define VRSM_SM_T1_US 53000
`define VRSM_SM_T2_US 106500
`define VRSM_SM_T4_US 535000
`define VRSM_SM_T5_US 1065000
`define VRSM_SM_T6_US 2665000
`define VRSM_SM_T7_US 5330000
`define VRSM_SM_CNT(us) (((us) * (`VRSM_SM_RATE_HZ / 1000)) / 1000)

`endif

//--- hw/vrsm_pkg.sv
`default_nettype none
package vrsm_pkg;

  // ramp direction of one channel
  typedef enum logic [2:0] {
    VRSM_IDLE = 3'h1,
    VRSM_DOWN = 3'h2,
    VRSM_UP = 3'h4
  } vrsm_ramp_e;

  typedef logic [7:0] vrsm_vol_t;
  typedef logic [18:0] vrsm_zcnt_t;

endpackage : vrsm_pkg

`default_nettype wire

//--- hw/vrsm_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "vrsm_defines.svh"

module vrsm_chan import vrsm_pkg::*; #(
  parameter int DELAY_SHIFT = 0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sample_valid_in,
  input wire logic sample_zero_in,
  input wire logic [2:0] delay_code_in,
  input wire logic mute_in,
  input wire logic fault_in,
  input wire vrsm_vol_t vol_target_in,
  input wire logic down_tick_in,
  input wire logic down_instant_in,
  input wire vrsm_vol_t down_amt_in,
  input wire logic up_tick_in,
  input wire logic up_instant_in,
  input wire vrsm_vol_t up_amt_in,
  output logic silence_met_out,
  output logic ramping_out,
  output vrsm_vol_t vol_out
);

  // zero-sample count per delay code; code 011 takes the nearest, 106.5 ms
  function automatic vrsm_zcnt_t delay_samples(input logic [2:0] code);
    int s;
    s = 0;
    case (code)
      3'h0: s = `VRSM_SM_CNT(`VRSM_SM_T0_US);
      3'h1: s = `VRSM_SM_CNT(`VRSM_SM_T1_US);
      3'h2, 3'h3: s = `VRSM_SM_CNT(`VRSM_SM_T2_US);
      3'h4: s = `VRSM_SM_CNT(`VRSM_SM_T4_US);
      3'h5: s = `VRSM_SM_CNT(`VRSM_SM_T5_US);
      3'h6: s = `VRSM_SM_CNT(`VRSM_SM_T6_US);
      default: s = `VRSM_SM_CNT(`VRSM_SM_T7_US);
    endcase
    s = s >> DELAY_SHIFT;
    if (s < 1) begin
      s = 1;
    end
    return vrsm_zcnt_t'(s);
  endfunction : delay_samples

  vrsm_zcnt_t zcnt_reg, zcnt_next, thr;
  vrsm_vol_t cur_reg, cur_next, target;
  vrsm_ramp_e state_reg, state_next;
  logic [8:0] sum, diff;

  // zero-sample counter, counts samples not clocks
  always_comb begin
    thr = delay_samples(delay_code_in);
    zcnt_next = zcnt_reg;
    if (sample_valid_in) begin
      if (!sample_zero_in) begin
        zcnt_next = '0;
      end else if (zcnt_reg < thr) begin
        zcnt_next = zcnt_reg + 19'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      zcnt_reg <= '0;
    end else begin
      zcnt_reg <= zcnt_next;
    end
  end

  assign silence_met_out = (zcnt_reg >= thr);

  // volume ramp toward the target, down or up
  always_comb begin
    target = (mute_in || fault_in) ? `VRSM_VOL_MUTE : vol_target_in;
    sum = {1'b0, cur_reg} + {1'b0, down_amt_in};
    diff = {1'b0, cur_reg} - {1'b0, up_amt_in};
    cur_next = cur_reg;
    state_next = VRSM_IDLE;
    case (1'b1)
      (cur_reg < target): begin
        state_next = VRSM_DOWN;
        if (down_instant_in) begin
          cur_next = target;
        end else if (down_tick_in) begin
          cur_next = (sum > {1'b0, target}) ? target : sum[7:0];
        end
      end
      (cur_reg > target): begin
        state_next = VRSM_UP;
        if (up_instant_in) begin
          cur_next = target;
        end else if (up_tick_in) begin
          cur_next = (diff[8] || diff[7:0] < target) ? target : diff[7:0];
        end
      end
      default: state_next = VRSM_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cur_reg <= `VRSM_VOL_MUTE;
      state_reg <= VRSM_IDLE;
    end else begin
      cur_reg <= cur_next;
      state_reg <= state_next;
    end
  end

  assign vol_out = cur_reg;
  assign ramping_out = (state_reg != VRSM_IDLE);

  AST_ZERO_RESTART: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    sample_valid_in && !sample_zero_in |=> zcnt_reg == '0)
    else $error("nonzero sample did not restart zero count");

  AST_ZERO_COUNT: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    sample_valid_in && sample_zero_in && zcnt_reg < thr
    |=> zcnt_reg == $past(zcnt_reg) + 19'h1)
    else $error("zero sample not counted");

  AST_UP_NORMAL: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    cur_reg > target && up_instant_in |=> cur_reg == $past(target))
    else $error("instant unmute did not restore volume");

endmodule : vrsm_chan

`default_nettype wire

//--- hw/vrsm_top.sv
// Behaviour
// - emergency rate 00/01/10 updates every 1, 2 or 4 sample periods
// - emergency rate 11 sets volume straight to mute
// - emergency step 00..11 lowers volume 4, 2, 1 or 0.5 dB per update
// - clock error or power loss uses emergency rate and step, not normal
// - joint bit set mutes each enabled channel only when both channels are silent
// - right enable bit allows right auto mute, resets enabled
// - left enable bit allows left auto mute, resets enabled
// - left delay code selects zero-sample run before left may mute
// - right delay code uses same table on right samples
// - delays are fixed sample counts, exact at 96 kHz
// - normal volume decreases use separate normal rate and step
`timescale 1ns/1ps
`default_nettype none
`include "vrsm_defines.svh"

module vrsm_top import vrsm_pkg::*; #(
  parameter int DELAY_SHIFT = 0
) (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic REG_WR_EN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic SAMPLE_VALID_IN,
  input wire logic [23:0] SAMPLE_LEFT_IN,
  input wire logic [23:0] SAMPLE_RIGHT_IN,
  input wire logic FAULT_IN,
  input wire logic [7:0] VOL_TARGET_IN,
  input wire logic [1:0] NORMAL_RAMP_RATE_IN,
  input wire logic [1:0] NORMAL_RAMP_DECREMENT_IN,
  input wire logic [1:0] NORMAL_RAMP_UP_RATE_IN,
  input wire logic [1:0] NORMAL_RAMP_UP_STEP_IN,
  output logic [7:0] VOL_LEFT_OUT,
  output logic [7:0] VOL_RIGHT_OUT,
  output logic LEFT_MUTED_OUT,
  output logic RIGHT_MUTED_OUT,
  output logic RAMP_BUSY_OUT
);

  // update strobe for a rate code, counted in sample periods
  function automatic logic rate_tick(input logic [1:0] rate,
                                     input logic valid,
                                     input logic [1:0] cnt);
    logic t;
    t = 1'b0;
    case (rate)
      `VRSM_RATE_FS1: t = valid;
      `VRSM_RATE_FS2: t = valid && (cnt[0] == 1'b0);
      `VRSM_RATE_FS4: t = valid && (cnt == 2'h0);
      default: t = 1'b0;
    endcase
    return t;
  endfunction : rate_tick

  // volume change per update for a step code
  function automatic vrsm_vol_t step_amt(input logic [1:0] code);
    vrsm_vol_t a;
    a = `VRSM_STEP_HALF_DB;
    case (code)
      2'h0: a = `VRSM_STEP_4DB;
      2'h1: a = `VRSM_STEP_2DB;
      2'h2: a = `VRSM_STEP_1DB;
      default: a = `VRSM_STEP_HALF_DB;
    endcase
    return a;
  endfunction : step_amt

  logic [7:0] emerg_reg, emerg_next;
  logic [7:0] smctl_reg, smctl_next;
  logic [7:0] smdly_reg, smdly_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] fs_cnt_reg, fs_cnt_next;
  logic mute_l_reg, mute_l_next;
  logic mute_r_reg, mute_r_next;
  logic [1:0] em_rate, em_step, dn_rate, dn_step;
  logic down_tick, down_instant, up_tick, up_instant;
  vrsm_vol_t down_amt, up_amt;
  logic met_l, met_r, busy_l, busy_r;
  logic joint, en_l, en_r;

  // register file: writes, and read data held for the presented address
  always_comb begin
    emerg_next = emerg_reg;
    smctl_next = smctl_reg;
    smdly_next = smdly_reg;
    if (REG_WR_EN_IN) begin
      case (REG_ADDR_IN)
        `VRSM_OFS_EMERG: emerg_next = REG_WDATA_IN;
        `VRSM_OFS_SMCTL: smctl_next = REG_WDATA_IN;
        `VRSM_OFS_SMDLY: smdly_next = REG_WDATA_IN;
        default: emerg_next = emerg_reg;
      endcase
    end
    case (REG_ADDR_IN)
      `VRSM_OFS_EMERG: rdata_next = emerg_reg;
      `VRSM_OFS_SMCTL: rdata_next = smctl_reg;
      `VRSM_OFS_SMDLY: rdata_next = smdly_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      emerg_reg <= `VRSM_RST_EMERG;
      smctl_reg <= `VRSM_RST_SMCTL;
      smdly_reg <= `VRSM_RST_SMDLY;
      rdata_reg <= 8'h00;
    end else begin
      emerg_reg <= emerg_next;
      smctl_reg <= smctl_next;
      smdly_reg <= smdly_next;
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA_OUT = rdata_reg;
  assign em_rate = emerg_reg[`VRSM_EM_RATE_HI:`VRSM_EM_RATE_LO];
  assign em_step = emerg_reg[`VRSM_EM_STEP_HI:`VRSM_EM_STEP_LO];
  assign joint = smctl_reg[`VRSM_SM_JOINT];
  assign en_r = smctl_reg[`VRSM_SM_EN_R];
  assign en_l = smctl_reg[`VRSM_SM_EN_L];

  // pick emergency or normal ramp-down settings, normal ramp-up settings
  always_comb begin
    dn_rate = FAULT_IN ? em_rate : NORMAL_RAMP_RATE_IN;
    dn_step = FAULT_IN ? em_step : NORMAL_RAMP_DECREMENT_IN;
    down_tick = rate_tick(dn_rate, SAMPLE_VALID_IN, fs_cnt_reg);
    down_instant = (dn_rate == `VRSM_RATE_INSTANT);
    down_amt = step_amt(dn_step);
    up_tick = rate_tick(NORMAL_RAMP_UP_RATE_IN, SAMPLE_VALID_IN,
                        fs_cnt_reg);
    up_instant = (NORMAL_RAMP_UP_RATE_IN == `VRSM_RATE_INSTANT);
    up_amt = step_amt(NORMAL_RAMP_UP_STEP_IN);
    fs_cnt_next = SAMPLE_VALID_IN ? fs_cnt_reg + 2'h1 : fs_cnt_reg;
  end

  // silence mute decision, joint or per channel
  always_comb begin
    mute_l_next = en_l && met_l && (!joint || met_r);
    mute_r_next = en_r && met_r && (!joint || met_l);
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      fs_cnt_reg <= 2'h0;
      mute_l_reg <= 1'b0;
      mute_r_reg <= 1'b0;
    end else begin
      fs_cnt_reg <= fs_cnt_next;
      mute_l_reg <= mute_l_next;
      mute_r_reg <= mute_r_next;
    end
  end

  // left channel
  vrsm_chan #(.DELAY_SHIFT(DELAY_SHIFT)) u_left (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(NRST_IN),
    .sample_valid_in(SAMPLE_VALID_IN),
    .sample_zero_in(SAMPLE_LEFT_IN == 24'h000000),
    .delay_code_in(smdly_reg[`VRSM_DLY_L_HI:`VRSM_DLY_L_LO]),
    .mute_in(mute_l_reg),
    .fault_in(FAULT_IN),
    .vol_target_in(VOL_TARGET_IN),
    .down_tick_in(down_tick),
    .down_instant_in(down_instant),
    .down_amt_in(down_amt),
    .up_tick_in(up_tick),
    .up_instant_in(up_instant),
    .up_amt_in(up_amt),
    .silence_met_out(met_l),
    .ramping_out(busy_l),
    .vol_out(VOL_LEFT_OUT)
  );

  // right channel
  vrsm_chan #(.DELAY_SHIFT(DELAY_SHIFT)) u_right (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(NRST_IN),
    .sample_valid_in(SAMPLE_VALID_IN),
    .sample_zero_in(SAMPLE_RIGHT_IN == 24'h000000),
    .delay_code_in(smdly_reg[`VRSM_DLY_R_HI:`VRSM_DLY_R_LO]),
    .mute_in(mute_r_reg),
    .fault_in(FAULT_IN),
    .vol_target_in(VOL_TARGET_IN),
    .down_tick_in(down_tick),
    .down_instant_in(down_instant),
    .down_amt_in(down_amt),
    .up_tick_in(up_tick),
    .up_instant_in(up_instant),
    .up_amt_in(up_amt),
    .silence_met_out(met_r),
    .ramping_out(busy_r),
    .vol_out(VOL_RIGHT_OUT)
  );

  assign LEFT_MUTED_OUT = mute_l_reg;
  assign RIGHT_MUTED_OUT = mute_r_reg;
  assign RAMP_BUSY_OUT = busy_l || busy_r;

  AST_EMERG_INSTANT: assert property (
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    FAULT_IN && em_rate == 2'h3 |=> VOL_LEFT_OUT == 8'hff)
    else $error("instant emergency mute missed");

  AST_EMERG_STEP: assert property (
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    FAULT_IN && em_rate == 2'h0 && em_step == 2'h0 && SAMPLE_VALID_IN
    && VOL_LEFT_OUT <= 8'hf7
    |=> VOL_LEFT_OUT == 8'($past(VOL_LEFT_OUT) + 8'h08))
    else $error("emergency step of 4 dB not applied");

  AST_EMERG_RATE4: assert property (
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    FAULT_IN && em_rate == 2'h2 && fs_cnt_reg != 2'h0
    |=> $stable(VOL_LEFT_OUT))
    else $error("volume moved between four-period updates");

  AST_EMERG_NOT_NORMAL: assert property (
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    FAULT_IN && em_rate != 2'h3 && !SAMPLE_VALID_IN
    |=> $stable(VOL_RIGHT_OUT))
    else $error("normal settings used during fault");

  AST_JOINT_WAIT: assert property (
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    joint && !met_r |=> !LEFT_MUTED_OUT)
    else $error("left muted alone in joint mode");

  AST_INDEP_MUTE: assert property (
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    !joint && en_l && met_l
    |=> LEFT_MUTED_OUT ##1 VOL_LEFT_OUT >= $past(VOL_LEFT_OUT))
    else $error("left did not mute on its own");

  AST_RIGHT_DISABLED: assert property (
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    !en_r |=> !RIGHT_MUTED_OUT)
    else $error("right muted while disabled");

endmodule : vrsm_top

`default_nettype wire

//--- testbench/vrsm_src.sv
`timescale 1ns/1ps
`default_nettype none

module vrsm_src (
  input wire logic clk_in,
  output logic valid_out,
  output logic [23:0] left_out,
  output logic [23:0] right_out
);
  logic zero_l = 1'b0;
  logic zero_r = 1'b0;

  // idle stream, data lines hold a non-zero pattern
  initial begin
    valid_out = 1'b0;
    left_out = 24'h5a5a5a;
    right_out = 24'ha5a5a5;
  end

  // one sample every five clocks; data inverts once valid is gone
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      #1;
      valid_out = 1'b1;
      left_out = zero_l ? 24'h000000 : 24'h000101;
      right_out = zero_r ? 24'h000000 : 24'h000203;
      @(posedge clk_in);
      #1;
      valid_out = 1'b0;
      left_out = ~left_out;
      right_out = ~right_out;
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask : send
endmodule : vrsm_src

`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int SHIFT = 8;
  localparam int DLY_US [8] = '{11500, 53000, 106500, 0, 535000, 1065000,
                                2665000, 5330000};
  localparam logic [7:0] EM_CFG [5] = '{8'h00, 8'h50, 8'ha0, 8'hf0, 8'h30};
  localparam logic [7:0] EM_EXP [5] = '{8'h50, 8'h38, 8'h32, 8'hff, 8'h34};
  localparam logic [7:0] JT_CTL [5] = '{8'h02, 8'h01, 8'h07, 8'h07, 8'h03};
  localparam logic [1:0] JT_Z [5] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h2};
  localparam logic [1:0] JT_EXP [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h2};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic fault = 1'b0;
  logic [7:0] target = 8'h30;
  logic [1:0] dn_rate = 2'h3;
  logic [1:0] dn_step = 2'h0;
  logic [1:0] up_rate = 2'h3;
  logic [1:0] up_step = 2'h0;
  logic [7:0] rdata, vol_l, vol_r;
  logic [23:0] s_left, s_right;
  logic s_valid, mute_l, mute_r, busy;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  // design and sample source
  vrsm_top #(.DELAY_SHIFT(SHIFT)) vrsm_top_inst (
    .SYS_CLK_IN(clk), .NRST_IN(rst_n), .REG_WR_EN_IN(wr_en),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .SAMPLE_VALID_IN(s_valid), .SAMPLE_LEFT_IN(s_left),
    .SAMPLE_RIGHT_IN(s_right), .FAULT_IN(fault), .VOL_TARGET_IN(target),
    .NORMAL_RAMP_RATE_IN(dn_rate), .NORMAL_RAMP_DECREMENT_IN(dn_step),
    .NORMAL_RAMP_UP_RATE_IN(up_rate), .NORMAL_RAMP_UP_STEP_IN(up_step),
    .VOL_LEFT_OUT(vol_l), .VOL_RIGHT_OUT(vol_r), .LEFT_MUTED_OUT(mute_l),
    .RIGHT_MUTED_OUT(mute_r), .RAMP_BUSY_OUT(busy));
  vrsm_src vrsm_src_inst (.clk_in(clk), .valid_out(s_valid),
    .left_out(s_left), .right_out(s_right));

  // clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      $display("[FAIL] %0t cycle limit reached", $time);
      fails++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    cyc(2);
    check(rdata, exp);
  endtask : rd

  task automatic settle;
    int n;
    n = 0;
    while (vol_l !== target && n < 100) begin
      cyc(1);
      n++;
    end
    check(vol_l, target);
  endtask : settle

  // reset values, read back, unmapped address
  task automatic t_regs;
    rd(8'h4f, 8'h30);
    rd(8'h50, 8'h07);
    rd(8'h51, 8'h00);
    wr(8'h51, 8'h5a);
    rd(8'h51, 8'h5a);
    wr(8'h52, 8'hff);
    rd(8'h52, 8'h00);
    wr(8'h51, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // fault ramp over four samples; normal down is instant to expose misuse
  task automatic t_emerg;
    for (int i = 0; i < 5; i++) begin
      settle();
      wr(8'h4f, EM_CFG[i]);
      fault = 1'b1;
      cyc(2);
      vrsm_src_inst.send(4);
      check(vol_l, EM_EXP[i]);
      check(vol_r, EM_EXP[i]);
      check({7'h00, busy}, (i == 3) ? 8'h00 : 8'h01);
      fault = 1'b0;
      cyc(2);
    end
    settle();
    $display("test emergency done");
  endtask : t_emerg

  // non-fault ramps follow the normal inputs, not the emergency field
  task automatic t_normal;
    dn_rate = 2'h0;
    dn_step = 2'h1;
    target = 8'h40;
    cyc(2);
    vrsm_src_inst.send(2);
    check(vol_l, 8'h38);
    dn_rate = 2'h3;
    up_rate = 2'h0;
    up_step = 2'h1;
    target = 8'h30;
    vrsm_src_inst.send(1);
    check(vol_l, 8'h34);
    up_rate = 2'h3;
    settle();
    $display("test normal done");
  endtask : t_normal

  // enables and joint mode at the shortest delay
  task automatic t_joint;
    wr(8'h51, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(8'h50, JT_CTL[i]);
      vrsm_src_inst.zero_l = JT_Z[i][1];
      vrsm_src_inst.zero_r = JT_Z[i][0];
      vrsm_src_inst.send((DLY_US[0] * 96 / 1000) >> SHIFT);
      check({6'h00, mute_l, mute_r}, 8'(JT_EXP[i]));
      vrsm_src_inst.zero_l = 1'b0;
      vrsm_src_inst.zero_r = 1'b0;
      vrsm_src_inst.send(1);
    end
    $display("test joint done");
  endtask : t_joint

  // every delay code except 011 on each channel, one sample short then exact
  task automatic t_silence;
    int thr;
    wr(8'h50, 8'h03);
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 8; c++) begin
        if (c == 3) continue;
        thr = (DLY_US[c] * 96 / 1000) >> SHIFT;
        wr(8'h51, {1'b0, c[2:0], 1'b0, c[2:0]});
        vrsm_src_inst.zero_l = (ch == 0);
        vrsm_src_inst.zero_r = (ch == 1);
        vrsm_src_inst.send(thr - 1);
        check({6'h00, mute_l, mute_r}, 8'h00);
        vrsm_src_inst.send(1);
        check({6'h00, mute_l, mute_r}, (ch == 1) ? 8'h01 : 8'h02);
        vrsm_src_inst.zero_l = 1'b0;
        vrsm_src_inst.zero_r = 1'b0;
        vrsm_src_inst.send(1);
        check({6'h00, mute_l, mute_r}, 8'h00);
      end
    end
    $display("test silence done");
  endtask : t_silence

  // reset for two cycles, then the tests in turn
  initial begin
    cyc(2);
    rst_n = 1'b1;
    t_regs();
    t_emerg();
    t_normal();
    t_joint();
    t_silence();
    summarize();
  end
endmodule : tb_top

`default_nettype wire
